// ---- bench/flash_irq_protect_ecc_regs_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module flash_irq_protect_ecc_regs_tb
    import fpe_pkg::*;
;
    // ----------
    // signals
    // ----------
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [10:0] pl = 11'h000;
    logic [2:0]  rs = 3'h0;
    logic        load_act = 1'b0;
    logic        boot_act = 1'b0;
    logic [1:0]  chk_sec = 2'h0;
    logic        chk_spare = 1'b0;
    logic [1:0]  chk_bits = 2'h0;
    logic [3:0]  fmain = 4'h0;
    logic [3:0]  fspare = 4'h0;
    logic        cyc, stb, we, ack, int_out, busy;
    logic [17:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r;
    logic [15:0] q;
    int          mismatches = 0;
    int          checks = 0;
    logic [15:0] ev_exp [6] = '{16'h8080, 16'h8080, 16'h8040, 16'h8020, 16'h8010, 16'h8000};
    int          cmd_seq [6] = '{7, 8, 6, 8, 7, 6};
    logic [15:0] cmd_exp [6] = '{16'h0004, 16'h0004, 16'h0002, 16'h0001, 16'h0001, 16'h0001};
    logic [4:0]  ecc_in [4] = '{5'h05, 5'h1a, 5'h0b, 5'h04};
    logic [15:0] ecc_exp [4] = '{16'h0001, 16'h8001, 16'h8081, 16'h8080};

    initial
    begin
        forever #25 clk = ~clk;
    end

    fpe_regs i_dut
    (
        .REF_CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .LOAD_DONE(pl[0]),
        .BOOT_DONE(pl[1]), .PROG_DONE(pl[2]), .ERASE_DONE(pl[3]), .RESET_CMD_DONE(pl[4]),
        .OTHER_CMD_DONE(pl[5]), .COLD_RST(rs[0]), .WARM_RST(rs[1]), .HOT_RST(rs[2]),
        .LOCK_CMD(pl[6]), .UNLOCK_CMD(pl[7]), .LOCK_TIGHT_CMD(pl[8]),
        .LOAD_ACTIVE(load_act), .BOOT_ACTIVE(boot_act), .ECC_CHK_VALID(pl[9]),
        .ECC_CHK_SECTOR(chk_sec), .ECC_CHK_SPARE(chk_spare), .ECC_ERR_BITS(chk_bits),
        .LOAD_FAIL(pl[10]), .FAIL_MAIN_MASK(fmain), .FAIL_SPARE_MASK(fspare),
        .INT_OUT(int_out), .INIT_BUSY(busy)
    );

    fpe_host i_host
    (
        .clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
        .dat_w(dat_w), .dat_r(dat_r), .ack(ack)
    );

    // ----------
    // tasks
    // ----------
    task automatic wr(input logic [15:0] a, input logic [15:0] dv);
        i_host.xfer(1'b1, a, dv, q);
    endtask

    task automatic rc(input logic [15:0] a, input logic [15:0] e);
        i_host.xfer(1'b0, a, 16'h0000, q);
        `CHK(q, e)
    endtask

    // whole-vector writes keep the task's automatic index out of the nonblocking target
    task automatic pulse(input int i);
        @(posedge clk);
        pl <= pl | (11'h001 << i);
        @(posedge clk);
        pl <= 11'h000;
    endtask

    task automatic dres(input int i);
        @(posedge clk);
        rs <= rs | (3'h1 << i);
        repeat (4) @(posedge clk);
        rs <= 3'h0;
        @(posedge clk);
    endtask

    // the protection sweep runs its full length; no parameter shortens it
    task automatic idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        `CHK(busy, 1'b0)
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("mismatch at %0t: timeout", $time);
        finish_test();
    end

    // ----------
    // sequence
    // ----------
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rc(16'hf241, 16'h8080);
        `CHK(int_out, 1'b1)
        rc(16'hf24c, 16'h0000);
        rc(16'hf24e, 16'h0002);
        rc(16'hff00, 16'h0000);
        rc(16'hf24d, 16'h0000);
        idle();
        wr(16'hf241, 16'h0000);
        foreach (ev_exp[i])
        begin
            pulse(i);
            wr(16'hf241, 16'hffff);
            rc(16'hf241, ev_exp[i]);
            `CHK(int_out, 1'b1)
            wr(16'hf241, 16'h0000);
            rc(16'hf241, 16'h0000);
            `CHK(int_out, 1'b0)
        end
        wr(16'hf300, 16'h0000);
        rc(16'hf241, 16'h0000);
        `CHK(int_out, 1'b1)
        pulse(2);
        rc(16'hf241, 16'h8040);
        `CHK(int_out, 1'b0)
        wr(16'hf241, 16'h0000);
        rc(16'hf241, 16'h0000);
        `CHK(int_out, 1'b1)
        wr(16'hf300, 16'h0001);
        wr(16'hf24c, 16'hffff);
        rc(16'hf24c, 16'h03ff);
        wr(16'hf301, 16'h0005);
        rc(16'hf24e, 16'h0002);
        wr(16'hf24c, 16'h0005);
        foreach (cmd_seq[i])
        begin
            pulse(cmd_seq[i]);
            rc(16'hf24e, cmd_exp[i]);
        end
        wr(16'hf24e, 16'hffff);
        rc(16'hf24e, 16'h0001);
        wr(16'hf301, 16'h0006);
        rc(16'hf24e, 16'h0002);
        load_act <= 1'b1;
        foreach (ecc_in[i])
        begin
            {chk_sec, chk_spare, chk_bits} <= ecc_in[i];
            pulse(9);
            rc(16'hff00, ecc_exp[i]);
        end
        fmain <= 4'h4;
        fspare <= 4'h2;
        pulse(10);
        rc(16'hff00, 16'h88a0);
        load_act <= 1'b0;
        boot_act <= 1'b1;
        {chk_sec, chk_spare, chk_bits} <= 5'h15;
        pulse(9);
        rc(16'hff00, 16'h89a0);
        boot_act <= 1'b0;
        {chk_sec, chk_spare, chk_bits} <= 5'h1d;
        pulse(9);
        rc(16'hff00, 16'h89a0);
        wr(16'hff00, 16'hffff);
        rc(16'hff00, 16'h89a0);
        load_act <= 1'b1;
        dres(1);
        load_act <= 1'b0;
        rc(16'hff00, 16'h0000);
        rc(16'hf241, 16'h8010);
        pulse(0);
        dres(2);
        rc(16'hf241, 16'h8010);
        wr(16'hf241, 16'h0000);
        dres(0);
        rc(16'hf241, 16'h8080);
        idle();
        finish_test();
    end
endmodule
bind fpe_regs fpe_regs_props i_props (.*);
`default_nettype wire

// ---- bench/fpe_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module fpe_host
    import fpe_pkg::*;
(
    // clock
    input  wire logic        clk,
    // wishbone master
    output var  logic        cyc   = 1'b0,
    output var  logic        stb   = 1'b0,
    output var  logic        we    = 1'b0,
    output var  logic [17:0] adr   = 18'h0_0000,
    output var  logic [3:0]  sel   = 4'h0,
    output var  logic [31:0] dat_w = 32'h0000_0000,
    input  wire logic [31:0] dat_r,
    input  wire logic        ack
);
    // one classic cycle; read data is taken at the ack edge only
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [15:0] dv,
                        output logic [15:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h3;
        dat_w <= {16'h0000, dv};
        do
            @(posedge clk);
        while (ack !== 1'b1);
        q = dat_r[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        // released lines must not keep the last value
        adr <= ~adr;
        dat_w <= ~dat_w;
    endtask
endmodule
`default_nettype wire

// ---- bench/fpe_regs_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module fpe_regs_props
    import fpe_pkg::*;
(
    // clock, reset and bus
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [17:0] ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    // completion events, device resets and interrupt pin
    input wire logic        LOAD_DONE,
    input wire logic        BOOT_DONE,
    input wire logic        PROG_DONE,
    input wire logic        ERASE_DONE,
    input wire logic        RESET_CMD_DONE,
    input wire logic        OTHER_CMD_DONE,
    input wire logic        COLD_RST,
    input wire logic        WARM_RST,
    input wire logic        HOT_RST,
    input wire logic        INT_OUT
);
    logic             pol_ff;
    wire logic        taken = CYC_I && STB_I && !ACK_O;
    wire logic        rd_q  = taken && !WE_I;
    wire logic [15:0] idx   = ADR_I[17:2];
    wire logic [15:0] d     = DAT_O[15:0];
    wire logic        dev_rst = COLD_RST || WARM_RST || HOT_RST;
    wire logic        ev = LOAD_DONE || BOOT_DONE || PROG_DONE || ERASE_DONE
                           || RESET_CMD_DONE || OTHER_CMD_DONE;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    // shadow of the pin polarity so pin checks hold for either setting
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            pol_ff <= 1'b1;
        else if (taken && WE_I && idx == 16'hf300 && SEL_I[0])
            pol_ff <= DAT_I[0];
    end

    sequence ack_pulse;
        ACK_O ##1 !ACK_O;
    endsequence
    sequence irq_zero_write;
        taken && WE_I && idx == 16'hf241 && SEL_I[1] && !DAT_I[15] && !ev;
    endsequence

    ack_once_a: assert property (taken |=> ack_pulse)
        else $error("bus request not acknowledged exactly once");
    int_set_a: assert property (ev && !dev_rst |-> ##2 INT_OUT == pol_ff)
        else $error("pin not active after completion event");
    int_clear_a: assert property (irq_zero_write |-> ##2 INT_OUT == !pol_ff)
        else $error("pin not inactive after master flag cleared");
    int_reset_a: assert property (dev_rst |-> ##2 INT_OUT == !pol_ff)
        else $error("pin not inactive during device reset");
    rsvd_irq_a: assert property (rd_q && idx == 16'hf241 |=> d[14:8] == 7'h0 && d[3:0] == 4'h0)
        else $error("reserved flag bits read nonzero");
    start_width_a: assert property (rd_q && idx == 16'hf24c |=> d[15:10] == 6'h0)
        else $error("start block upper bits nonzero");
    prot_onehot_a: assert property (rd_q && idx == 16'hf24e |=> $onehot(d[2:0]) && d[15:3] == 13'h0)
        else $error("protection state not one-hot");
    ecc_code_a: assert property (rd_q && idx == 16'hff00 |=> (d & (d >> 1) & 16'h5555) == 16'h0)
        else $error("reserved ecc code reported");
    rsvd_blk_a: assert property (rd_q && idx == 16'hf24d |=> d == 16'h0)
        else $error("reserved register reads nonzero");
    upper_zero_a: assert property (ACK_O |-> DAT_O[31:16] == 16'h0)
        else $error("upper read half nonzero");
endmodule
`default_nettype wire

// ---- logic/fpe_defines.svh ----
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH

// register indices; byte address is four times the index
`define FPE_IDX_IRQ_FLAGS   16'hf241
`define FPE_IDX_START_BLOCK 16'hf24c
`define FPE_IDX_END_BLOCK   16'hf24d
`define FPE_IDX_PROT_STATE  16'hf24e
`define FPE_IDX_ECC_RESULTS 16'hff00
`define FPE_IDX_IRQ_CONFIG  16'hf300
`define FPE_IDX_BLOCK_SEL   16'hf301

// interrupt flag bit positions
`define FPE_BIT_MASTER      15
`define FPE_BIT_LOAD        7
`define FPE_BIT_PROG        6
`define FPE_BIT_ERASE       5
`define FPE_BIT_RESET       4

// reset values
`define FPE_RST_IRQ_COLD    16'h8080
`define FPE_RST_IRQ_WARM    16'h8010
`define FPE_RST_START_BLOCK 16'h0000
`define FPE_RST_PROT_STATE  16'h0002
`define FPE_RST_ECC         16'h0000
`define FPE_RST_POLARITY    1'b1

// block array
`define FPE_BLOCK_AW        10
`define FPE_BLOCK_COUNT     1024
`define FPE_BLOCK_LAST      10'h3ff

`endif

// ---- logic/fpe_pkg.sv ----
package fpe_pkg;

    typedef enum logic [1:0]
    {
        PROT_UNLOCKED = 2'b00,
        PROT_LOCKED   = 2'b01,
        PROT_TIGHT    = 2'b10
    } fpe_prot_t;

    typedef enum logic [1:0]
    {
        ECC_NONE    = 2'b00,
        ECC_FIXED   = 2'b01,
        ECC_UNFIXED = 2'b10
    } fpe_ecc_t;

    typedef enum logic [0:0]
    {
        INIT_SWEEP = 1'b0,
        INIT_RUN   = 1'b1
    } fpe_init_t;

endpackage

// ---- logic/fpe_regs.sv ----
// How it works
// RULE_01: interrupt pin follows master flag bit 15
// RULE_02: cleared master drives pin to inactive polarity
// RULE_03: master flag sets on any completion event
// RULE_04: flags reset to 8080h cold, 8010h warm/hot
// RULE_05: load-done bit 7 sets on load finish
// RULE_06: program-done bit 6 sets on program finish
// RULE_07: erase-done bit 5 sets on erase finish
// RULE_08: reset-done bit 4 sets on reset completion
// RULE_09: master/load/program/erase clear by zero or reset
// RULE_10: reset-done clears only by host zero write
// RULE_11: ones and reserved writes change nothing
// RULE_12: host loads start block before lock commands
// RULE_13: start block field ten bits, RW, reset zero
// RULE_14: host selects block before reading protection
// RULE_15: protection state one-hot unlocked/locked/tight
// RULE_16: protection register read-only, reset 0002h
// RULE_17: ECC flags single/double errors, ignores more; the code reports three errors as code 10
// RULE_18: result codes 00 none, 01 fixed, 10 fatal
// RULE_19: eight two-bit fields, sector 3 main on top
// RULE_20: ECC fields update on load and boot load
// RULE_21: ECC register read-only, reset 0000h
// RULE_22: load ended by reset leaves fields 00
// RULE_23: failed load reports 10 in affected fields
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "fpe_defines.svh"

module fpe_regs
    import fpe_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    // wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [17:0] ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // controller events, one-cycle pulses
    input  wire logic        LOAD_DONE,
    input  wire logic        BOOT_DONE,
    input  wire logic        PROG_DONE,
    input  wire logic        ERASE_DONE,
    input  wire logic        RESET_CMD_DONE,
    input  wire logic        OTHER_CMD_DONE,
    // device resets in progress, levels
    input  wire logic        COLD_RST,
    input  wire logic        WARM_RST,
    input  wire logic        HOT_RST,
    // write protection commands, one-cycle pulses
    input  wire logic        LOCK_CMD,
    input  wire logic        UNLOCK_CMD,
    input  wire logic        LOCK_TIGHT_CMD,
    // ecc check results
    input  wire logic        LOAD_ACTIVE,
    input  wire logic        BOOT_ACTIVE,
    input  wire logic        ECC_CHK_VALID,
    input  wire logic [1:0]  ECC_CHK_SECTOR,
    input  wire logic        ECC_CHK_SPARE,
    input  wire logic [1:0]  ECC_ERR_BITS,
    input  wire logic        LOAD_FAIL,
    input  wire logic [3:0]  FAIL_MAIN_MASK,
    input  wire logic [3:0]  FAIL_SPARE_MASK,
    // interrupt pin and protection sweep busy
    output logic             INT_OUT,
    output logic             INIT_BUSY
);

    //--------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------
    function automatic logic [1:0] ecc_code(input logic [1:0] nbits);
        // three or more errors alias onto the double-bit code
        ecc_code = (nbits == 2'd0) ? ECC_NONE :
                   (nbits == 2'd1) ? ECC_FIXED : ECC_UNFIXED; // [RULE_17] [RULE_18]
    endfunction

    function automatic logic [2:0] prot_onehot(input fpe_prot_t st);
        case (st)
            PROT_UNLOCKED: prot_onehot = 3'b100; // [RULE_15]
            PROT_LOCKED:   prot_onehot = 3'b010;
            PROT_TIGHT:    prot_onehot = 3'b001;
            default:       prot_onehot = 3'b010;
        endcase
    endfunction

    //--------------------------------------------------------------
    // bus decode
    //--------------------------------------------------------------
    logic        ack_ff;
    logic        req;
    logic        wr;
    logic [15:0] idx;
    logic [15:0] wmask;
    logic [15:0] wdat;

    assign req   = CYC_I & STB_I & ~ack_ff;
    assign wr    = req & WE_I;
    assign idx   = ADR_I[17:2];
    assign wmask = {{8{SEL_I[1]}}, {8{SEL_I[0]}}};
    assign wdat  = DAT_I[15:0];

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            ack_ff <= 1'b0;
        else
            ack_ff <= req;
    end
    assign ACK_O = ack_ff;

    //--------------------------------------------------------------
    // device reset tracking
    //--------------------------------------------------------------
    logic any_rst;
    logic cold_ff;
    logic warm_ff;
    logic cold_rel;
    logic warm_rel;

    assign any_rst = COLD_RST | WARM_RST | HOT_RST;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cold_ff <= 1'b0;
            warm_ff <= 1'b0;
        end
        else
        begin
            cold_ff <= COLD_RST;
            warm_ff <= WARM_RST | HOT_RST;
        end
    end
    assign cold_rel = cold_ff & ~COLD_RST;
    assign warm_rel = warm_ff & ~(WARM_RST | HOT_RST) & ~COLD_RST;

    //--------------------------------------------------------------
    // interrupt flags
    //--------------------------------------------------------------
    logic        master_ff;
    logic        load_ff;
    logic        prog_ff;
    logic        erase_ff;
    logic        rstdone_ff;
    logic        polarity_ff;
    logic        wr_irq;
    logic [15:0] clr;
    logic        set_load;
    logic        set_rst;

    assign wr_irq   = wr & (idx == `FPE_IDX_IRQ_FLAGS);
    // only a written zero on an enabled lane clears; ones do nothing
    assign clr      = wr_irq ? (wmask & ~wdat) : 16'h0000; // [RULE_11]
    assign set_load = LOAD_DONE | BOOT_DONE; // [RULE_05]
    assign set_rst  = RESET_CMD_DONE | warm_rel; // [RULE_08]

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            master_ff <= 1'(`FPE_RST_IRQ_COLD >> `FPE_BIT_MASTER);
            load_ff   <= 1'b1;
            prog_ff   <= 1'b0;
            erase_ff  <= 1'b0;
        end
        else if (any_rst)
        begin
            // flags held clear while a reset runs
            master_ff <= 1'b0; // [RULE_09]
            load_ff   <= 1'b0;
            prog_ff   <= 1'b0;
            erase_ff  <= 1'b0;
        end
        else if (cold_rel)
        begin
            master_ff <= 1'b1; // [RULE_04]
            load_ff   <= 1'b1;
            prog_ff   <= 1'b0;
            erase_ff  <= 1'b0;
        end
        else if (warm_rel)
        begin
            master_ff <= 1'b1; // [RULE_04]
            load_ff   <= 1'b0;
            prog_ff   <= 1'b0;
            erase_ff  <= 1'b0;
        end
        else
        begin
            // a set arriving with a clear wins
            master_ff <= (master_ff & ~clr[`FPE_BIT_MASTER]) | set_load | PROG_DONE
                         | ERASE_DONE | set_rst | OTHER_CMD_DONE; // [RULE_03] [RULE_09]
            load_ff   <= (load_ff & ~clr[`FPE_BIT_LOAD]) | set_load; // [RULE_05]
            prog_ff   <= (prog_ff & ~clr[`FPE_BIT_PROG]) | PROG_DONE; // [RULE_06]
            erase_ff  <= (erase_ff & ~clr[`FPE_BIT_ERASE]) | ERASE_DONE; // [RULE_07]
        end
    end

    // survives device resets; only a host zero clears it
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            rstdone_ff <= 1'b0;
        else
            rstdone_ff <= (rstdone_ff & ~clr[`FPE_BIT_RESET]) | set_rst; // [RULE_10] [RULE_08]
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            polarity_ff <= `FPE_RST_POLARITY;
        else if (wr & (idx == `FPE_IDX_IRQ_CONFIG) & SEL_I[0])
            polarity_ff <= wdat[0];
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            INT_OUT <= `FPE_RST_POLARITY;
        else
            INT_OUT <= polarity_ff ? master_ff : ~master_ff; // [RULE_01] [RULE_02]
    end

    //--------------------------------------------------------------
    // start block and block select
    //--------------------------------------------------------------
    logic [`FPE_BLOCK_AW-1:0] start_ff;
    logic [`FPE_BLOCK_AW-1:0] sel_ff;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            start_ff <= `FPE_BLOCK_AW'(`FPE_RST_START_BLOCK);
        else if (wr & (idx == `FPE_IDX_START_BLOCK))
            start_ff <= (start_ff & ~wmask[9:0]) | (wdat[9:0] & wmask[9:0]); // [RULE_13]
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            sel_ff <= '0;
        else if (wr & (idx == `FPE_IDX_BLOCK_SEL))
            sel_ff <= (sel_ff & ~wmask[9:0]) | (wdat[9:0] & wmask[9:0]);
    end

    //--------------------------------------------------------------
    // block protection array
    //--------------------------------------------------------------
    // no reset on the array: a sweep writes locked into every block,
    // trading 1024 cycles after reset for far fewer flops
    fpe_prot_t                prot_mem [`FPE_BLOCK_COUNT];
    fpe_init_t                init_ff;
    logic [`FPE_BLOCK_AW-1:0] sweep_ff;
    fpe_prot_t                cur_st;
    fpe_prot_t                nxt_st;
    logic                     cmd_any;
    logic [2:0]               prot_bits;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            init_ff  <= INIT_SWEEP;
            sweep_ff <= '0;
        end
        else if (COLD_RST)
        begin
            init_ff  <= INIT_SWEEP;
            sweep_ff <= '0;
        end
        else
        begin
            case (init_ff)
                INIT_SWEEP:
                begin
                    sweep_ff <= sweep_ff + 1'b1;
                    if (sweep_ff == `FPE_BLOCK_LAST)
                        init_ff <= INIT_RUN;
                end
                INIT_RUN:
                    init_ff <= INIT_RUN;
                default:
                    init_ff <= INIT_SWEEP;
            endcase
        end
    end
    assign INIT_BUSY = (init_ff == INIT_SWEEP);

    assign cur_st  = prot_mem[start_ff];
    assign cmd_any = LOCK_CMD | UNLOCK_CMD | LOCK_TIGHT_CMD;

    // a tight lock refuses unlock and lock until the next cold reset
    always_comb
    begin
        nxt_st = cur_st;
        if (cur_st != PROT_TIGHT)
        begin
            if (LOCK_TIGHT_CMD)
                nxt_st = (cur_st == PROT_LOCKED) ? PROT_TIGHT : cur_st;
            else if (LOCK_CMD)
                nxt_st = PROT_LOCKED;
            else if (UNLOCK_CMD)
                nxt_st = PROT_UNLOCKED;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (init_ff == INIT_SWEEP)
            prot_mem[sweep_ff] <= PROT_LOCKED;
        else if (cmd_any)
            prot_mem[start_ff] <= nxt_st; // [RULE_12]
    end

    // the sweep leaves every block locked, so report locked meanwhile
    assign prot_bits = (init_ff == INIT_SWEEP) ? 3'b010
                       : prot_onehot(prot_mem[sel_ff]); // [RULE_14] [RULE_16]

    //--------------------------------------------------------------
    // ecc results
    //--------------------------------------------------------------
    logic [15:0] ecc_ff;
    logic [15:0] ecc_upd;
    logic [15:0] ecc_fail;
    logic [3:0]  fpos;
    logic        in_load;

    assign in_load = LOAD_ACTIVE | BOOT_ACTIVE;
    // sector n main at bits 4n+3:4n+2, spare at 4n+1:4n
    assign fpos    = {ECC_CHK_SECTOR, ECC_CHK_SPARE ? 2'b00 : 2'b10}; // [RULE_19]

    always_comb
    begin
        ecc_upd = ecc_ff;
        ecc_upd[fpos +: 2] = ecc_code(ECC_ERR_BITS);
        ecc_fail = ecc_ff;
        for (int i = 0; i < 4; i++)
        begin
            if (FAIL_MAIN_MASK[i])
                ecc_fail[4*i+2 +: 2] = ECC_UNFIXED; // [RULE_23]
            if (FAIL_SPARE_MASK[i])
                ecc_fail[4*i +: 2] = ECC_UNFIXED;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            ecc_ff <= `FPE_RST_ECC; // [RULE_21]
        else if (any_rst)
            ecc_ff <= `FPE_RST_ECC; // [RULE_22]
        else if (LOAD_FAIL)
            ecc_ff <= ecc_fail;
        else if (ECC_CHK_VALID & in_load)
            ecc_ff <= ecc_upd; // [RULE_20]
    end

    //--------------------------------------------------------------
    // read mux
    //--------------------------------------------------------------
    logic [15:0] rd;

    always_comb
    begin
        case (idx)
            `FPE_IDX_IRQ_FLAGS:
                rd = {master_ff, 7'h00, load_ff, prog_ff, erase_ff, rstdone_ff, 4'h0}; // [RULE_11]
            `FPE_IDX_START_BLOCK:
                rd = {6'h00, start_ff};
            `FPE_IDX_PROT_STATE:
                rd = {13'h0000, prot_bits};
            `FPE_IDX_ECC_RESULTS:
                rd = ecc_ff;
            `FPE_IDX_IRQ_CONFIG:
                rd = {15'h0000, polarity_ff};
            `FPE_IDX_BLOCK_SEL:
                rd = {6'h00, sel_ff};
            default:
                rd = 16'h0000;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            DAT_O <= 32'h0000_0000;
        else if (req & ~WE_I)
            DAT_O <= {16'h0000, rd};
    end

endmodule

`default_nettype wire
